// ===== rtl/wts_channel.sv
// One channel's day and time match against a given weekday and time
`default_nettype none
`include "wts_params.svh"
module wts_channel (
    input wire wts_pkg::wts_day_t day_i,
    input wire wts_pkg::wts_hour_t hour_i,
    input wire wts_pkg::wts_min_t min_i,
    input wire wts_pkg::wts_day_t start_day_i,
    input wire wts_pkg::wts_day_t end_day_i,
    input wire logic on_set_i,
    input wire wts_pkg::wts_hour_t on_hour_i,
    input wire wts_pkg::wts_min_t on_min_i,
    input wire logic off_set_i,
    input wire wts_pkg::wts_hour_t off_hour_i,
    input wire wts_pkg::wts_min_t off_min_i,
    output logic on_hit_o,
    output logic off_hit_o
);
    import wts_pkg::*;

    function automatic logic day_in(input wts_day_t d, input wts_day_t s, input wts_day_t e);
        day_in = (s <= e) ? (d >= s && d <= e) : (d >= s || d <= e);
    endfunction

    function automatic wts_day_t day_next(input wts_day_t d);
        day_next = (d == `WTS_DAY_SU) ? `WTS_DAY_MO : wts_day_t'(d + 3'h1);
    endfunction

    wire logic active = (start_day_i != `WTS_DAY_NONE);
    wire wts_day_t eff_end = (end_day_i == `WTS_DAY_NONE) ? start_day_i : end_day_i;
    wire logic on_ok = on_set_i && on_hour_i <= `WTS_HOUR_MAX && on_min_i <= `WTS_MIN_MAX;
    wire logic off_ok = off_set_i && off_hour_i <= `WTS_HOUR_MAX && off_min_i <= `WTS_MIN_MAX;
    // Off not after on: one continuous period, on at start day, off at end day, or the day after start for a one-day range
    wire logic overnight = on_ok && off_ok && {off_hour_i, off_min_i} <= {on_hour_i, on_min_i};
    wire wts_day_t off_last = (start_day_i == eff_end) ? day_next(start_day_i) : eff_end;
    wire logic in_range = day_in(day_i, start_day_i, eff_end);
    wire logic on_day = overnight ? (day_i == start_day_i) : in_range;
    wire logic off_day = overnight ? (day_i == off_last) : in_range;
    wire logic on_match = on_ok && hour_i == on_hour_i && min_i == on_min_i;
    wire logic off_match = off_ok && hour_i == off_hour_i && min_i == off_min_i;

    assign on_hit_o = active && on_day && on_match;
    assign off_hit_o = active && off_day && off_match;
endmodule // wts_channel
`default_nettype wire

// ===== rtl/wts_params.svh
// Constants for the weekly time switch block
// Functional notes
// - Four channels A to D per block, all driving one shared switch_output.
// - start_day is first day for switch-on; end_day is last day for switch-off.
// - On and off times are hour:minute 00:00 to 23:59, or unset.
// - Day codes are Monday to Sunday plus a no-day value.
// - Parameter-visibility flag per block, enabled after reset.
// - Multi-day range with off after on applies on and off time on every day inside it.
// - Off time earlier than on time means switch-off on a following day.
// - Friday to Monday, 16:00 on, 6:00 off holds output on all weekend.
// - First channel reaching its on time sets the output to one.
// - First channel reaching its off time clears output, whatever others do.
// - On and off at the same moment leaves the output at zero.
// - At power-up output is recomputed from all settings and current time.
// - On 00:00 Monday, off 00:00 Tuesday gives 24 hours on.
// - Without power the output stays open and no events take effect.
`ifndef WTS_PARAMS_SVH
`define WTS_PARAMS_SVH

`define WTS_NUM_CH 4
`define WTS_DAY_NONE 3'h0
`define WTS_DAY_MO 3'h1
`define WTS_DAY_SU 3'h7
`define WTS_HOUR_MAX 5'h17
`define WTS_MIN_MAX 6'h3B
`define WTS_WEEK_MINUTES 10080
`define WTS_SCAN_CNT_W 14
`define WTS_PARAM_VIS_RST 1'b1

`endif

// ===== rtl/wts_pkg.sv
// Types shared by the weekly time switch modules
`default_nettype none
package wts_pkg;
    typedef logic [2:0] wts_day_t;
    typedef logic [4:0] wts_hour_t;
    typedef logic [5:0] wts_min_t;
    typedef enum logic [1:0] {
        WTS_ST_DOWN,
        WTS_ST_SCAN,
        WTS_ST_RUN
    } wts_state_t;
endpackage
`default_nettype wire

// ===== rtl/wts_time_step.sv
// Steps a weekday and time back by one minute, wrapping over the week
`default_nettype none
`include "wts_params.svh"
module wts_time_step (
    input wire wts_pkg::wts_day_t day_i,
    input wire wts_pkg::wts_hour_t hour_i,
    input wire wts_pkg::wts_min_t min_i,
    output logic [2:0] day_o,
    output logic [4:0] hour_o,
    output logic [5:0] min_o
);
    import wts_pkg::*;

    wire logic min_wrap = (min_i == 6'h00);
    wire logic hour_wrap = min_wrap && (hour_i == 5'h00);

    assign min_o = min_wrap ? `WTS_MIN_MAX : wts_min_t'(min_i - 6'h01);
    assign hour_o = !min_wrap ? hour_i : (hour_i == 5'h00) ? `WTS_HOUR_MAX : wts_hour_t'(hour_i - 5'h01);
    assign day_o = !hour_wrap ? day_i : (day_i == `WTS_DAY_MO) ? `WTS_DAY_SU : wts_day_t'(day_i - 3'h1);
endmodule // wts_time_step
`default_nettype wire

// ===== rtl/wts_weekly_switch_block.sv
// Weekly time switch: four channels, power-up recompute, one switching output
`default_nettype none
`include "wts_params.svh"
module wts_weekly_switch_block #(
    parameter int SCAN_LEN = `WTS_WEEK_MINUTES
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic power_ok_i,
    input wire logic tick_i,
    input wire wts_pkg::wts_day_t rtc_day_i,
    input wire wts_pkg::wts_hour_t rtc_hour_i,
    input wire wts_pkg::wts_min_t rtc_min_i,
    input wire wts_pkg::wts_day_t [3:0] start_day_i,
    input wire wts_pkg::wts_day_t [3:0] end_day_i,
    input wire logic [3:0] on_set_i,
    input wire wts_pkg::wts_hour_t [3:0] on_hour_i,
    input wire wts_pkg::wts_min_t [3:0] on_min_i,
    input wire logic [3:0] off_set_i,
    input wire wts_pkg::wts_hour_t [3:0] off_hour_i,
    input wire wts_pkg::wts_min_t [3:0] off_min_i,
    input wire logic param_vis_we_i,
    input wire logic param_vis_i,
    output logic switch_output_o,
    output logic param_vis_o,
    output logic scan_busy_o,
    output logic [3:0] ch_on_o,
    output logic [3:0] ch_off_o,
    output logic [1:0] last_ch_o
);
    import wts_pkg::*;

    // Power pin is asynchronous to clk_i
    logic pwr_meta_r;
    logic pwr_sync_r;

    wts_state_t state_r;
    wts_state_t state_nxt;

    logic out_r;
    logic out_nxt;
    logic vis_r;
    logic [3:0] ch_on_r;
    logic [3:0] ch_on_nxt;
    logic [3:0] ch_off_r;
    logic [3:0] ch_off_nxt;
    logic [1:0] last_ch_r;
    logic [1:0] last_ch_nxt;

    // Last minute evaluated live, so each minute fires once
    wts_day_t last_day_r;
    wts_hour_t last_hour_r;
    wts_min_t last_min_r;

    // Probe time walking backward during the power-up scan
    wts_day_t probe_day_r;
    wts_hour_t probe_hour_r;
    wts_min_t probe_min_r;
    logic [`WTS_SCAN_CNT_W-1:0] scan_cnt_r;

    wire logic scanning = (state_r == WTS_ST_SCAN);
    wire logic powered = pwr_sync_r;

    // Evaluation time: the live clock, or the probe while scanning
    wire wts_day_t eval_day = scanning ? probe_day_r : rtc_day_i;
    wire wts_hour_t eval_hour = scanning ? probe_hour_r : rtc_hour_i;
    wire wts_min_t eval_min = scanning ? probe_min_r : rtc_min_i;

    wire logic [3:0] on_hit;
    wire logic [3:0] off_hit;

    // One matcher per channel, all fed the same evaluation time
    genvar g;
    generate
        for (g = 0; g < `WTS_NUM_CH; g = g + 1) begin : g_ch
            wts_channel u_ch (
                .day_i(eval_day),
                .hour_i(eval_hour),
                .min_i(eval_min),
                .start_day_i(start_day_i[g]),
                .end_day_i(end_day_i[g]),
                .on_set_i(on_set_i[g]),
                .on_hour_i(on_hour_i[g]),
                .on_min_i(on_min_i[g]),
                .off_set_i(off_set_i[g]),
                .off_hour_i(off_hour_i[g]),
                .off_min_i(off_min_i[g]),
                .on_hit_o(on_hit[g]),
                .off_hit_o(off_hit[g])
            );
        end
    endgenerate

    // Any channel may switch; off beats on further down
    wire logic any_on = |on_hit;
    wire logic any_off = |off_hit;

    wire logic [2:0] prev_day;
    wire logic [4:0] prev_hour;
    wire logic [5:0] prev_min;

    // One minute earlier than the probe, for the backward scan
    wts_time_step u_step (
        .day_i(probe_day_r),
        .hour_i(probe_hour_r),
        .min_i(probe_min_r),
        .day_o(prev_day),
        .hour_o(prev_hour),
        .min_o(prev_min)
    );

    // Lowest channel number with a hit, for the status output
    function automatic logic [1:0] first_ch(input logic [3:0] v);
        if (v[0]) begin
            first_ch = 2'h0;
        end else if (v[1]) begin
            first_ch = 2'h1;
        end else if (v[2]) begin
            first_ch = 2'h2;
        end else begin
            first_ch = 2'h3;
        end
    endfunction

    // A new minute reached on a processing cycle
    wire logic running = (state_r == WTS_ST_RUN);
    wire logic day_moved = (rtc_day_i != last_day_r);
    wire logic hour_moved = (rtc_hour_i != last_hour_r);
    wire logic min_moved = (rtc_min_i != last_min_r);
    wire logic new_minute = tick_i && (day_moved || hour_moved || min_moved);
    wire logic live_eval = running && powered && new_minute;

    // Probe count bounds the scan; a week of minutes fits the counter
    localparam logic [`WTS_SCAN_CNT_W-1:0] SCAN_LAST = `WTS_SCAN_CNT_W'(SCAN_LEN - 1);
    wire logic scan_last = (scan_cnt_r == SCAN_LAST);
    wire logic scan_found = any_on || any_off;
    wire logic scan_done = scanning && (scan_found || scan_last || !powered);

    // While down, probe and last-seen minute follow the live clock
    wire logic track_live = (state_r == WTS_ST_DOWN);
    wire logic probe_step = scanning && !scan_done;

    always_comb begin
        state_nxt = state_r;
        out_nxt = out_r;
        ch_on_nxt = 4'h0;
        ch_off_nxt = 4'h0;
        last_ch_nxt = last_ch_r;
        case (state_r)
            WTS_ST_DOWN: begin
                // Contact stays open until the recompute has decided
                out_nxt = 1'b0;
                if (powered) begin
                    state_nxt = WTS_ST_SCAN;
                end
            end
            WTS_ST_SCAN: begin
                if (!powered) begin
                    state_nxt = WTS_ST_DOWN;
                    out_nxt = 1'b0;
                end else if (any_off) begin
                    // Most recent event was a switch-off; outage does not revive the output
                    state_nxt = WTS_ST_RUN;
                    out_nxt = 1'b0;
                    last_ch_nxt = first_ch(off_hit);
                end else if (any_on) begin
                    state_nxt = WTS_ST_RUN;
                    out_nxt = 1'b1;
                    last_ch_nxt = first_ch(on_hit);
                end else if (scan_last) begin
                    // A whole week holds no event: nothing ever switches on
                    state_nxt = WTS_ST_RUN;
                    out_nxt = 1'b0;
                end
            end
            WTS_ST_RUN: begin
                if (!powered) begin
                    state_nxt = WTS_ST_DOWN;
                    out_nxt = 1'b0;
                end else if (live_eval) begin
                    ch_on_nxt = on_hit;
                    ch_off_nxt = off_hit;
                    if (any_off) begin
                        out_nxt = 1'b0;
                        last_ch_nxt = first_ch(off_hit);
                    end else if (any_on) begin
                        out_nxt = 1'b1;
                        last_ch_nxt = first_ch(on_hit);
                    end
                end
            end
            default: begin
                state_nxt = WTS_ST_DOWN;
                out_nxt = 1'b0;
            end
        endcase
    end

    // Only the second flop is read, so a late edge costs a cycle, not a glitch
    always_ff @(posedge clk_i) begin
        pwr_meta_r <= power_ok_i;
        pwr_sync_r <= pwr_meta_r;
        if (!rst_b_i) begin
            pwr_meta_r <= 1'b0;
            pwr_sync_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_r <= WTS_ST_DOWN;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            out_r <= 1'b0;
        end else begin
            out_r <= out_nxt;
        end
    end

    // Status is for display only; switching never reads it back
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ch_on_r <= 4'h0;
            ch_off_r <= 4'h0;
            last_ch_r <= 2'h0;
        end else begin
            ch_on_r <= ch_on_nxt;
            ch_off_r <= ch_off_nxt;
            last_ch_r <= last_ch_nxt;
        end
    end

    // Scan starts at the current minute, so an event due now counts
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            probe_day_r <= `WTS_DAY_MO;
            probe_hour_r <= 5'h00;
            probe_min_r <= 6'h00;
        end else if (track_live) begin
            probe_day_r <= rtc_day_i;
            probe_hour_r <= rtc_hour_i;
            probe_min_r <= rtc_min_i;
        end else if (probe_step) begin
            probe_day_r <= prev_day;
            probe_hour_r <= prev_hour;
            probe_min_r <= prev_min;
        end
    end

    // Without this limit a week holding no event would scan forever
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            scan_cnt_r <= '0;
        end else if (track_live) begin
            scan_cnt_r <= '0;
        end else if (probe_step) begin
            scan_cnt_r <= `WTS_SCAN_CNT_W'(scan_cnt_r + 1'b1);
        end
    end

    // Minute the scan started from is treated as already evaluated
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            last_day_r <= `WTS_DAY_NONE;
            last_hour_r <= 5'h00;
            last_min_r <= 6'h00;
        end else if (track_live) begin
            last_day_r <= rtc_day_i;
            last_hour_r <= rtc_hour_i;
            last_min_r <= rtc_min_i;
        end else if (live_eval) begin
            last_day_r <= rtc_day_i;
            last_hour_r <= rtc_hour_i;
            last_min_r <= rtc_min_i;
        end
    end

    // Display flag only; the switching logic never looks at it
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            vis_r <= `WTS_PARAM_VIS_RST;
        end else if (param_vis_we_i) begin
            vis_r <= param_vis_i;
        end
    end

    // Gated by the synced power level too, so the contact opens at once
    assign switch_output_o = out_r && powered;
    assign param_vis_o = vis_r;
    assign scan_busy_o = scanning;
    assign ch_on_o = ch_on_r;
    assign ch_off_o = ch_off_r;
    assign last_ch_o = last_ch_r;
endmodule // wts_weekly_switch_block
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the weekly time switch
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import wts_pkg::*;
    logic clk_i, rst_b_i, power_ok_i, tick_i, param_vis_we_i, param_vis_i, ld, stp;
    wts_day_t rtc_day_i, ld_d, d;
    wts_hour_t rtc_hour_i, ld_h, h;
    wts_min_t rtc_min_i, ld_m, m;
    wts_day_t [3:0] start_day_i, end_day_i;
    wts_hour_t [3:0] on_hour_i, off_hour_i;
    wts_min_t [3:0] on_min_i, off_min_i;
    logic [3:0] on_set_i, off_set_i, ch_on_o, ch_off_o, seen_on, seen_off;
    logic switch_output_o, param_vis_o, scan_busy_o;
    logic [1:0] last_ch_o;
    int fails = 0;
    int num_checks = 0;
    int unsigned seed;
    wts_weekly_switch_block #(.SCAN_LEN(64)) DUT (.clk_i, .rst_b_i, .power_ok_i, .tick_i, .rtc_day_i,
        .rtc_hour_i, .rtc_min_i, .start_day_i, .end_day_i, .on_set_i, .on_hour_i, .on_min_i, .off_set_i,
        .off_hour_i, .off_min_i, .param_vis_we_i, .param_vis_i, .switch_output_o, .param_vis_o,
        .scan_busy_o, .ch_on_o, .ch_off_o, .last_ch_o);
    wts_rtc_model u_rtc (.clk_i, .load_i(ld), .step_i(stp), .day_i(ld_d), .hour_i(ld_h), .min_i(ld_m),
        .day_o(rtc_day_i), .hour_o(rtc_hour_i), .min_o(rtc_min_i), .tick_o(tick_i));
    always #5 clk_i = ~clk_i;
    // Pulses last one cycle, so collect them mid-cycle
    always @(negedge clk_i) begin
        seen_on = seen_on | ch_on_o;
        seen_off = seen_off | ch_off_o;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: expected %0h got %0h", $time, exp, got);
        end
    endtask
    function automatic logic [3:0] exp_sw(input logic on_hit, input logic off_hit, input logic prev);
        return {3'h0, off_hit ? 1'b0 : (on_hit | prev)};
    endfunction
    task automatic clr();
        start_day_i = '0;
        end_day_i = '0;
        on_set_i = 4'h0;
        off_set_i = 4'h0;
        on_hour_i = '0;
        on_min_i = '0;
        off_hour_i = '0;
        off_min_i = '0;
    endtask
    task automatic chan(input int i, input wts_day_t s, input wts_day_t e, input logic a, input wts_hour_t ah,
        input wts_min_t am, input logic b, input wts_hour_t bh, input wts_min_t bm);
        start_day_i[i] = s;
        end_day_i[i] = e;
        on_set_i[i] = a;
        on_hour_i[i] = ah;
        on_min_i[i] = am;
        off_set_i[i] = b;
        off_hour_i[i] = bh;
        off_min_i[i] = bm;
    endtask
    // Load a time, let it settle, then advance one minute
    task automatic at(input wts_day_t dd, input wts_hour_t hh, input wts_min_t mm);
        ld_d = dd;
        ld_h = hh;
        ld_m = mm;
        ld = 1'b1;
        cyc(1);
        ld = 1'b0;
        cyc(2);
        seen_on = 4'h0;
        seen_off = 4'h0;
        stp = 1'b1;
        cyc(1);
        stp = 1'b0;
        cyc(3);
    endtask
    task automatic wait_scan();
        cyc(4);
        cmp({3'h0, scan_busy_o}, 4'h1);
        for (int k = 0; k < 100 && scan_busy_o !== 1'b0; k++) cyc(1);
        cmp({3'h0, scan_busy_o}, 4'h0);
    endtask
    initial begin
        #100us;
        fails++;
        tally_and_finish();
    end
    initial begin
        clk_i = 1'b0;
        rst_b_i = 1'b0;
        power_ok_i = 1'b0;
        param_vis_we_i = 1'b0;
        param_vis_i = 1'b0;
        ld = 1'b0;
        stp = 1'b0;
        clr();
        seed = $urandom(32'h3B49);
        cyc(6);
        rst_b_i = 1'b1;
        cyc(1);
        cmp({3'h0, param_vis_o}, 4'h1);
        param_vis_we_i = 1'b1;
        cyc(1);
        param_vis_we_i = 1'b0;
        cyc(1);
        cmp({3'h0, param_vis_o}, 4'h0);
        chan(0, 3'h0, 3'h7, 1'b1, 5'h00, 6'h01, 1'b0, 5'h00, 6'h00);
        power_ok_i = 1'b1;
        wait_scan();
        at(3'h1, 5'h00, 6'h00);
        cmp(seen_on, 4'h0);
        $display("test no_day done");
        h = 5'($urandom_range(1, 20));
        m = 6'($urandom_range(1, 59));
        d = 3'($urandom_range(1, 5));
        chan(0, 3'h1, 3'h5, 1'b1, h, m, 1'b1, h + 5'h02, m);
        at(d, h, m - 6'h01);
        cmp({3'h0, switch_output_o}, exp_sw(1'b1, 1'b0, 1'b0));
        cmp(seen_on, 4'h1);
        at(d, h + 5'h02, m - 6'h01);
        cmp(seen_off, 4'h1);
        cmp({3'h0, switch_output_o}, exp_sw(1'b0, 1'b1, 1'b1));
        at(3'h6, h, m - 6'h01);
        cmp(seen_on, 4'h0);
        $display("test day_range done");
        clr();
        chan(1, 3'h1, 3'h7, 1'b0, 5'h00, 6'h00, 1'b1, 5'h0C, 6'h00);
        chan(2, 3'h1, 3'h7, 1'b1, 5'h0B, 6'h00, 1'b0, 5'h00, 6'h00);
        chan(3, 3'h1, 3'h7, 1'b1, 5'h0C, 6'h00, 1'b0, 5'h00, 6'h00);
        at(3'h3, 5'h0A, 6'h3B);
        cmp({3'h0, switch_output_o}, exp_sw(1'b1, 1'b0, 1'b0));
        at(3'h3, 5'h0B, 6'h3B);
        cmp({3'h0, switch_output_o}, exp_sw(1'b1, 1'b1, 1'b1));
        cmp(seen_off | seen_on, 4'hA);
        cmp({2'h0, last_ch_o}, 4'h1);
        $display("test overlap done");
        clr();
        chan(0, 3'h5, 3'h1, 1'b1, 5'h10, 6'h00, 1'b1, 5'h06, 6'h00);
        at(3'h5, 5'h0F, 6'h3B);
        cmp({3'h0, switch_output_o}, 4'h1);
        at(3'h6, 5'h05, 6'h3B);
        cmp(seen_off, 4'h0);
        at(3'h1, 5'h05, 6'h3B);
        cmp({3'h0, switch_output_o}, 4'h0);
        $display("test weekend done");
        clr();
        chan(0, 3'h3, 3'h0, 1'b1, 5'h17, 6'h3B, 1'b0, 5'h17, 6'h3B);
        chan(1, 3'h4, 3'h0, 1'b0, 5'h00, 6'h00, 1'b1, 5'h17, 6'h3B);
        at(3'h3, 5'h17, 6'h3A);
        cmp(seen_on, 4'h1);
        cmp(seen_off, 4'h0);
        cmp({3'h0, switch_output_o}, 4'h1);
        at(3'h4, 5'h17, 6'h3A);
        cmp(seen_on | seen_off, 4'h2);
        cmp({3'h0, switch_output_o}, 4'h0);
        $display("test single_day done");
        chan(0, 3'h1, 3'h2, 1'b1, 5'h00, 6'h00, 1'b1, 5'h00, 6'h00);
        at(3'h7, 5'h17, 6'h3B);
        at(3'h1, 5'h0B, 6'h3B);
        cmp({3'h0, switch_output_o}, 4'h1);
        at(3'h1, 5'h17, 6'h3B);
        cmp({3'h0, switch_output_o}, 4'h0);
        $display("test full_day done");
        chan(0, 3'h1, 3'h7, 1'b1, 5'h0F, 6'h00, 1'b1, 5'h10, 6'h00);
        at(3'h2, 5'h0E, 6'h3B);
        cmp({3'h0, switch_output_o}, 4'h1);
        power_ok_i = 1'b0;
        cyc(4);
        cmp({3'h0, switch_output_o}, 4'h0);
        at(3'h2, 5'h0F, 6'h1E);
        at(3'h2, 5'h10, 6'h1E);
        power_ok_i = 1'b1;
        wait_scan();
        cmp({3'h0, switch_output_o}, 4'h0);
        power_ok_i = 1'b0;
        cyc(4);
        at(3'h3, 5'h0F, 6'h1E);
        power_ok_i = 1'b1;
        wait_scan();
        cmp({3'h0, switch_output_o}, 4'h1);
        $display("test power_loss done");
        tally_and_finish();
    end
endmodule  // testbench
`default_nettype wire

// ===== tb/wts_rtc_model.sv
// Real-time clock partner: weekday and minute counter with a load port
`default_nettype none
module wts_rtc_model (
    input wire logic clk_i,
    input wire logic load_i,
    input wire logic step_i,
    input wire wts_pkg::wts_day_t day_i,
    input wire wts_pkg::wts_hour_t hour_i,
    input wire wts_pkg::wts_min_t min_i,
    output var wts_pkg::wts_day_t day_o,
    output var wts_pkg::wts_hour_t hour_o,
    output var wts_pkg::wts_min_t min_o,
    output var logic tick_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import wts_pkg::*;
    initial begin
        day_o = 3'h1;
        hour_o = 5'h00;
        min_o = 6'h00;
        tick_o = 1'b0;
    end
    // Cycle strobe every other clock, so repeated ticks in one minute occur
    always @(posedge clk_i) begin
        tick_o <= ~tick_o;
        if (load_i) begin
            day_o <= day_i;
            hour_o <= hour_i;
            min_o <= min_i;
        end else if (step_i) begin
            min_o <= (min_o == 6'h3B) ? 6'h00 : min_o + 6'h01;
            if (min_o == 6'h3B) begin
                hour_o <= (hour_o == 5'h17) ? 5'h00 : hour_o + 5'h01;
                if (hour_o == 5'h17) day_o <= (day_o == 3'h7) ? 3'h1 : day_o + 3'h1;
            end
        end
    end
endmodule  // wts_rtc_model
`default_nettype wire

// ===== tb/wts_weekly_switch_block_asserts.sv
// Port-level checks for the weekly time switch
`default_nettype none
module wts_switch_asserts #(
    parameter int SCAN_LEN = 64
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic power_ok_i,
    input wire wts_pkg::wts_day_t rtc_day_i,
    input wire wts_pkg::wts_hour_t rtc_hour_i,
    input wire wts_pkg::wts_min_t rtc_min_i,
    input wire logic param_vis_we_i,
    input wire logic param_vis_i,
    input wire logic switch_output_o,
    input wire logic param_vis_o,
    input wire logic scan_busy_o,
    input wire logic [3:0] ch_on_o,
    input wire logic [3:0] ch_off_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import wts_pkg::*;
    localparam int SCAN_MAX = SCAN_LEN + 2;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence power_gone;
        !power_ok_i [*2];
    endsequence
    sequence minute_held;
        $stable(rtc_day_i) && $stable(rtc_hour_i) && $stable(rtc_min_i);
    endsequence
    vis_write_a: assert property (param_vis_we_i |=> param_vis_o == $past(param_vis_i))
        else $error("visibility flag not written");
    power_open_a: assert property (power_gone |-> ##1 !switch_output_o)
        else $error("output closed without supply");
    on_sets_a: assert property ((|ch_on_o && ch_off_o == 4'h0 && $past(power_ok_i, 2)) |-> switch_output_o)
        else $error("on event did not close output");
    off_wins_a: assert property (|ch_off_o |-> !switch_output_o)
        else $error("off event left output closed");
    event_once_a: assert property ((|ch_on_o || |ch_off_o) ##0 minute_held |=> ch_on_o == 4'h0 && ch_off_o == 4'h0)
        else $error("event fired twice in one minute");
    scan_bound_a: assert property ($rose(scan_busy_o) |-> ##[1:SCAN_MAX] !scan_busy_o)
        else $error("recompute scan too long");
    scan_quiet_a: assert property (scan_busy_o |-> ch_on_o == 4'h0 && ch_off_o == 4'h0)
        else $error("live event during scan");
    rise_cause_a: assert property ($rose(switch_output_o) |-> (|ch_on_o) || $fell(scan_busy_o))
        else $error("output closed without cause");
    drop_cause_a: assert property ($fell(switch_output_o) |-> (|ch_off_o) || !$past(power_ok_i, 2))
        else $error("output opened without cause");
endmodule  // wts_switch_asserts
bind wts_weekly_switch_block wts_switch_asserts #(.SCAN_LEN(SCAN_LEN)) u_chk (.clk_i, .rst_b_i, .power_ok_i,
    .rtc_day_i, .rtc_hour_i, .rtc_min_i, .param_vis_we_i, .param_vis_i, .switch_output_o, .param_vis_o,
    .scan_busy_o, .ch_on_o, .ch_off_o);
`default_nettype wire
